/* File: rtl/bcc_pkg.sv */
package bcc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] BCC_OFS_DRIVE = 8'h72;
  localparam logic [7:0] BCC_OFS_START = 8'h73;
  localparam logic [7:0] BCC_OFS_TUNE = 8'h74;
  localparam logic [7:0] BCC_OFS_SLOPE = 8'h80;
  localparam logic [7:0] BCC_OFS_STATUS = 8'h81;
  localparam logic [7:0] BCC_RST_DRIVE = 8'h00;
  localparam logic [7:0] BCC_RST_START = 8'h00;
  localparam logic [7:0] BCC_RST_TUNE = 8'h00;
  localparam logic [2:0] BCC_RST_SLOPE = 3'h0;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BCC_DRV_HI = 7;
  localparam int BCC_DRV_LO = 6;
  localparam int BCC_ADAPT_BIT = 5;
  localparam int BCC_JUMP_BIT = 4;
  localparam int BCC_THR_HI = 3;
  localparam int BCC_THR_LO = 2;
  localparam int BCC_STEP_HI = 1;
  localparam int BCC_STEP_LO = 0;
  localparam int BCC_VCODE_HI = 5;
  localparam int BCC_LLC_HI = 7;
  localparam int BCC_LLC_LO = 6;
  localparam int BCC_JIT_HI = 5;
  localparam int BCC_JIT_LO = 4;
  localparam int BCC_KI_HI = 3;
  localparam int BCC_KI_LO = 2;
  localparam int BCC_KP_HI = 1;
  localparam int BCC_KP_LO = 0;
  // ************************************************************
  // voltage code: 16 V + 0.5 V per step, control code in 1/8 V
  // ************************************************************
  localparam logic [8:0] BCC_CTRL_MAX = 9'h0FC;
  localparam logic [3:0] BCC_CTRL_PER_CODE = 4'h4;
  // brightness threshold percentages, 16-bit brightness scale
  localparam logic [6:0] BCC_PCT_10 = 7'h0A;
  localparam logic [6:0] BCC_PCT_30 = 7'h1E;
  localparam logic [6:0] BCC_PCT_50 = 7'h32;
  localparam logic [6:0] BCC_PCT_70 = 7'h46;
  localparam logic [6:0] BCC_PCT_FULL = 7'h64;
  // jitter filter selections
  typedef enum logic [3:0] {
    BCC_JF_BYPASS = 4'h1,
    BCC_JF_300K = 4'h2,
    BCC_JF_60K = 4'h4,
    BCC_JF_30K = 4'h8
  } bcc_jitter_e;
endpackage : bcc_pkg

/* File: rtl/bcc_regs.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module bcc_regs
  import bcc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int BRT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NCH-1:0] cluster_mode,
  input wire logic pwm_cycle,
  input wire logic [BRT_W-1:0] brightness,
  input wire logic headroom_low,
  input wire logic headroom_high,
  output logic [1:0] gate_drive_level,
  output logic [1:0] light_load_threshold,
  output logic [3:0] jitter_select,
  output logic [2:0] integral_gain,
  output logic [2:0] proportional_gain,
  output logic [8:0] boost_ctrl_code,
  output logic tracking_active,
  output logic jump_pulse
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] drive_reg;
  logic [5:0] vcode_reg;
  logic [7:0] tune_reg;
  logic [2:0] voltage_step_rate_reg;
  logic [7:0] rdata_reg;
  logic [8:0] ctrl_reg;
  logic [8:0] ctrl_next;
  logic [4:0] slope_cnt_reg;
  logic [BRT_W-1:0] brt_ref_reg;
  logic jump_reg;
  logic tracking_voltage_enable;
  logic [1:0] fast_step_trigger_level;
  logic [4:0] step_period;
  logic [8:0] jump_steps;
  logic [6:0] thr_pct;
  logic [BRT_W+6:0] rise_scaled;
  logic [BRT_W+6:0] ref_scaled;
  logic rise_big;
  logic step_tick;
  logic [8:0] start_ctrl;

  assign tracking_voltage_enable = drive_reg[BCC_ADAPT_BIT];
  assign fast_step_trigger_level = drive_reg[BCC_THR_HI:BCC_THR_LO];
  assign start_ctrl = 9'(vcode_reg) * 9'(BCC_CTRL_PER_CODE);

  // software writes; config bytes hold their value until reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_reg <= BCC_RST_DRIVE;
      vcode_reg <= BCC_RST_START[BCC_VCODE_HI:0];
      tune_reg <= BCC_RST_TUNE;
      voltage_step_rate_reg <= BCC_RST_SLOPE;
    end else if (reg_wr) begin
      case (reg_addr)
        BCC_OFS_DRIVE: drive_reg <= reg_wdata;
        BCC_OFS_START: vcode_reg <= reg_wdata[BCC_VCODE_HI:0];
        BCC_OFS_TUNE: tune_reg <= reg_wdata;
        BCC_OFS_SLOPE: voltage_step_rate_reg <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise and for unmapped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        BCC_OFS_DRIVE: rdata_reg <= drive_reg;
        BCC_OFS_START: rdata_reg <= {2'h0, vcode_reg};
        BCC_OFS_TUNE: rdata_reg <= tune_reg;
        BCC_OFS_SLOPE: rdata_reg <= {5'h00, voltage_step_rate_reg};
        BCC_OFS_STATUS: rdata_reg <= {tracking_active, jump_reg, 6'(ctrl_reg[8:3])};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign reg_rdata = rdata_reg;

  // ************************************************************
  // static analog settings
  // ************************************************************
  // drive level code
  assign gate_drive_level = drive_reg[BCC_DRV_HI:BCC_DRV_LO];
  assign light_load_threshold = tune_reg[BCC_LLC_HI:BCC_LLC_LO];
  assign integral_gain = {1'b0, tune_reg[BCC_KI_HI:BCC_KI_LO]} + 3'h1;
  assign proportional_gain = {1'b0, tune_reg[BCC_KP_HI:BCC_KP_LO]} + 3'h1;

  always_comb begin
    case (tune_reg[BCC_JIT_HI:BCC_JIT_LO])
      2'h0: jitter_select = BCC_JF_BYPASS;
      2'h1: jitter_select = BCC_JF_300K;
      2'h2: jitter_select = BCC_JF_60K;
      default: jitter_select = BCC_JF_30K;
    endcase
  end

  // ************************************************************
  // tracking voltage control
  // ************************************************************
  // cluster override
  assign tracking_active = tracking_voltage_enable & ~(&cluster_mode);

  // rate field to cycle count, 6 then 8 then 16 breaks the linear run
  always_comb begin
    case (voltage_step_rate_reg)
      3'h6: step_period = 5'h08;
      3'h7: step_period = 5'h10;
      default: step_period = {2'h0, voltage_step_rate_reg} + 5'h01;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slope_cnt_reg <= 5'h00;
    end else if (!tracking_active) begin
      slope_cnt_reg <= 5'h00;
    end else if (pwm_cycle) begin
      slope_cnt_reg <= step_tick ? 5'h00 : slope_cnt_reg + 5'h01;
    end
  end
  assign step_tick = pwm_cycle && (slope_cnt_reg + 5'h01 >= step_period);

  always_comb begin
    case (drive_reg[BCC_STEP_HI:BCC_STEP_LO])
      2'h0: jump_steps = 9'h008;
      2'h1: jump_steps = 9'h010;
      2'h2: jump_steps = 9'h020;
      default: jump_steps = 9'h040;
    endcase
  end

  // threshold percent, compared as rise*100 >= ref*pct
  always_comb begin
    case (fast_step_trigger_level)
      2'h0: thr_pct = BCC_PCT_10;
      2'h1: thr_pct = BCC_PCT_30;
      2'h2: thr_pct = BCC_PCT_50;
      default: thr_pct = BCC_PCT_70;
    endcase
  end
  assign rise_scaled = (BRT_W+7)'(brightness - brt_ref_reg) * (BRT_W+7)'(BCC_PCT_FULL);
  assign ref_scaled = (BRT_W+7)'(brt_ref_reg) * (BRT_W+7)'(thr_pct);
  assign rise_big = (brightness > brt_ref_reg) && (rise_scaled >= ref_scaled);

  // jump only when allowed and tracking
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      jump_reg <= 1'b0;
    end else begin
      jump_reg <= tracking_active && drive_reg[BCC_JUMP_BIT] && rise_big;
    end
  end
  assign jump_pulse = jump_reg;

  // brightness reference follows falls and jumps, so small creeps add up until they reach the threshold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brt_ref_reg <= '0;
    end else if (rise_big && tracking_active && drive_reg[BCC_JUMP_BIT]) begin
      brt_ref_reg <= brightness;
    end else if (brightness < brt_ref_reg || !tracking_active) begin
      brt_ref_reg <= brightness;
    end
  end

  // control code next value, saturating at the top of range
  always_comb begin
    ctrl_next = ctrl_reg;
    if (!tracking_active) begin
      ctrl_next = start_ctrl;
    end else if (jump_reg) begin
      ctrl_next = (10'(ctrl_reg) + 10'(jump_steps) > 10'(BCC_CTRL_MAX)) ?
                  BCC_CTRL_MAX : ctrl_reg + jump_steps;
    end else if (step_tick && headroom_low && ctrl_reg < BCC_CTRL_MAX) begin
      ctrl_next = ctrl_reg + 9'h001;
    end else if (step_tick && headroom_high && !headroom_low && ctrl_reg != 9'h000) begin
      ctrl_next = ctrl_reg - 9'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= 9'h000;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  assign boost_ctrl_code = ctrl_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rd_start;
    reg_rd && reg_addr == BCC_OFS_START;
  endsequence

  sequence s_wr_drive;
    reg_wr && reg_addr == BCC_OFS_DRIVE;
  endsequence

  sequence s_wr_start;
    reg_wr && reg_addr == BCC_OFS_START;
  endsequence

  sequence s_wr_tune;
    reg_wr && reg_addr == BCC_OFS_TUNE;
  endsequence

  // a step slot: tracking, no jump pending, divider tick present
  sequence s_step_slot;
    tracking_active && !jump_pulse && step_tick;
  endsequence

  a_reserved_read_zero: assert property (s_rd_start |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_fixed_hold_code: assert property (!tracking_active ##1 !tracking_active
    |-> boost_ctrl_code == $past(start_ctrl))
    else $error("fixed voltage not held");
  a_cluster_force_off: assert property (&cluster_mode |-> !tracking_active)
    else $error("cluster did not force off");
  a_jump_needs_enable: assert property (jump_pulse |-> $past(drive_reg[BCC_JUMP_BIT]))
    else $error("jump without enable");
  a_jump_needs_rise: assert property (jump_pulse |-> $past(rise_big))
    else $error("jump without threshold");
  a_jump_step_size: assert property (jump_pulse && tracking_active &&
    10'(boost_ctrl_code) + 10'(jump_steps) <= 10'(BCC_CTRL_MAX)
    |=> boost_ctrl_code == $past(boost_ctrl_code) + $past(jump_steps))
    else $error("jump step wrong");
  a_code_in_range: assert property (boost_ctrl_code <= BCC_CTRL_MAX)
    else $error("code above range");
  a_step_rate_limit: assert property (tracking_active && !jump_pulse && !step_tick
    ##1 tracking_active && !jump_pulse |-> $stable(boost_ctrl_code))
    else $error("step outside tick");
  a_gain_range: assert property (integral_gain >= 3'h1 && integral_gain <= 3'h4)
    else $error("gain out of range");
  a_prop_gain_range: assert property (proportional_gain >= 3'h1 && proportional_gain <= 3'h4)
    else $error("proportional gain out of range");
  a_drive_follows_write: assert property (s_wr_drive |=>
    gate_drive_level == $past(reg_wdata[BCC_DRV_HI:BCC_DRV_LO]))
    else $error("drive level not taken");
  a_llc_follows_write: assert property (s_wr_tune |=>
    light_load_threshold == $past(reg_wdata[BCC_LLC_HI:BCC_LLC_LO]))
    else $error("light load threshold not taken");
  a_start_code_taken: assert property (s_wr_start |=>
    vcode_reg == $past(reg_wdata[BCC_VCODE_HI:0]))
    else $error("start code not taken");
  a_jitter_one_hot: assert property ($onehot(jitter_select))
    else $error("jitter select not one-hot");
  a_jitter_bypass: assert property (tune_reg[BCC_JIT_HI:BCC_JIT_LO] == 2'h0 |->
    jitter_select == BCC_JF_BYPASS)
    else $error("jitter filter not bypassed");
  // low headroom raises the code, a surplus lowers it, only in a step slot
  a_step_up_low: assert property (s_step_slot ##0
    (headroom_low && boost_ctrl_code < BCC_CTRL_MAX)
    |=> boost_ctrl_code == $past(boost_ctrl_code) + 9'h001)
    else $error("step up missed");
  a_step_down_high: assert property (s_step_slot ##0
    (headroom_high && !headroom_low && boost_ctrl_code != 9'h000)
    |=> boost_ctrl_code == $past(boost_ctrl_code) - 9'h001)
    else $error("step down missed");
  a_jump_saturates: assert property (jump_pulse && tracking_active &&
    10'(boost_ctrl_code) + 10'(jump_steps) > 10'(BCC_CTRL_MAX)
    |=> boost_ctrl_code == BCC_CTRL_MAX)
    else $error("jump not saturated");
endmodule : bcc_regs
`default_nettype wire

/* File: testbench/tb_bcc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_bcc_regs;
  import bcc_pkg::*;
  // ************************************************************
  // stimulus and design under test
  // ************************************************************
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pwm_cycle = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] cluster_mode = 4'h0, jitter_select;
  logic [15:0] brightness = 16'h1000;
  logic headroom_low = 1'b0, headroom_high = 1'b0, tracking_active, jump_pulse;
  logic [1:0] gate_drive_level, light_load_threshold;
  logic [2:0] integral_gain, proportional_gain;
  logic [8:0] boost_ctrl_code, exp_code;
  int bad_count = 0, num_checks = 0, cycles = 0, jumps = 0;
  always #2 clk = ~clk;
  bcc_regs bcc_regs_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cluster_mode(cluster_mode), .pwm_cycle(pwm_cycle), .brightness(brightness),
    .headroom_low(headroom_low), .headroom_high(headroom_high),
    .gate_drive_level(gate_drive_level), .light_load_threshold(light_load_threshold),
    .jitter_select(jitter_select), .integral_gain(integral_gain),
    .proportional_gain(proportional_gain), .boost_ctrl_code(boost_ctrl_code),
    .tracking_active(tracking_active), .jump_pulse(jump_pulse));
  // ************************************************************
  // helpers
  // ************************************************************
  // jump pulses are one cycle long, so they are counted rather than polled
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (jump_pulse === 1'b1) jumps <= jumps + 1;
    if (cycles == 20000) tally_and_finish(1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) pwm_cycle <= 1'b1;
      @(posedge clk) pwm_cycle <= 1'b0;
      idle(3);
    end
  endtask : pulses
  task automatic tally_and_finish(input int timed_out);
    bad_count += timed_out;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(BCC_OFS_DRIVE, 8'h00);
    rd(BCC_OFS_START, 8'h00);
    rd(BCC_OFS_TUNE, 8'h00);
    rd(8'h75, 8'h00);
    chk(jitter_select, 16'h0001);
    wr(BCC_OFS_START, 8'hFF);
    rd(BCC_OFS_START, 8'h3F);
    chk(boost_ctrl_code, 16'h00FC);
    wr(BCC_OFS_TUNE, 8'h5A);
    rd(BCC_OFS_TUNE, 8'h5A);
    // every code of every tune field and of the drive level reaches its output
    for (int k = 0; k < 4; k++) begin
      wr(BCC_OFS_TUNE, {k[1:0], k[1:0], k[1:0], k[1:0]});
      wr(BCC_OFS_DRIVE, {k[1:0], 6'h00});
      idle(1);
      chk(gate_drive_level, k);
      chk(light_load_threshold, k);
      chk(jitter_select, 16'h0001 << k);
      chk(integral_gain, k + 1);
      chk(proportional_gain, k + 1);
    end
    wr(BCC_OFS_START, 8'h10);
    headroom_low <= 1'b1;
    pulses(2);
    chk(boost_ctrl_code, 16'h0040);
    // tracking steps once per cycle, then once per two cycles
    wr(BCC_OFS_DRIVE, 8'h20);
    idle(1);
    chk(tracking_active, 16'h0001);
    pulses(4);
    chk(boost_ctrl_code, 16'h0044);
    wr(BCC_OFS_SLOPE, 8'h01);
    pulses(4);
    chk(boost_ctrl_code, 16'h0046);
    rd(BCC_OFS_SLOPE, 8'h01);
    // a surplus of headroom walks the code down at the same rate
    headroom_low <= 1'b0;
    headroom_high <= 1'b1;
    pulses(2);
    chk(boost_ctrl_code, 16'h0045);
    headroom_high <= 1'b0;
    headroom_low <= 1'b0;
    cluster_mode <= 4'hF;
    idle(2);
    chk(tracking_active, 16'h0000);
    chk(boost_ctrl_code, 16'h0040);
    cluster_mode <= 4'h7;
    idle(2);
    chk(tracking_active, 16'h0001);
    // a large rise with jumps disabled leaves the code alone
    brightness <= 16'hF000;
    idle(6);
    chk(jumps, 16'h0000);
    chk(boost_ctrl_code, 16'h0040);
    // a small rise below the top threshold gives no jump
    brightness <= 16'h1000;
    wr(BCC_OFS_DRIVE, 8'h3C);
    idle(4);
    brightness <= 16'h1800;
    idle(6);
    chk(jumps, 16'h0000);
    // each step size, then saturation at the top code
    exp_code = 9'h040;
    for (int k = 0; k < 6; k++) begin
      brightness <= 16'h1000;
      wr(BCC_OFS_DRIVE, {4'h3, k[1:0], (k > 3) ? 2'h3 : k[1:0]});
      idle(4);
      brightness <= 16'hF000;
      idle(6);
      exp_code = exp_code + (9'h008 << ((k > 3) ? 3 : k));
      if (exp_code > 9'h0FC) exp_code = 9'h0FC;
      chk(jumps, k + 1);
      chk(boost_ctrl_code, exp_code);
    end
    rd(BCC_OFS_STATUS, 8'h9F);
    // a reset in mid-run returns every setting to its cleared value
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    rd(BCC_OFS_DRIVE, 8'h00);
    chk(boost_ctrl_code, 16'h0000);
    chk(jitter_select, 16'h0001);
    tally_and_finish(0);
  end
endmodule : tb_bcc_regs
`default_nettype wire
